// [hdl/dfir_pkg.sv]
// shared constants for the decimating fir filter: register map, fields, coefficient sets
// assumes a 40 MHz aclk and an axi4-lite register bus with 32-bit data
package dfir_pkg;
  localparam int SAMPLE_W = 12;    // converter sample width
  localparam int COEF_W   = 12;    // signed coefficient width
  localparam int OUT_W    = 16;    // filtered output width
  localparam int NUM_COEF = 12;    // unique coefficients h0..h11
  localparam int NUM_TAPS = 24;    // full even-length delay line
  localparam int ACC_W    = 29;    // 25-bit products, 12 summed
  localparam int FRAC_W   = 11;    // coefficient fraction bits
  localparam int FIFO_W   = 16;
  localparam int FIFO_D   = 8;
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL      = 8'h00;
  localparam logic [7:0] IDX_STATUS    = 8'h01;
  localparam logic [7:0] IDX_COEF_BASE = 8'h5a;  // h0 .. h11 at 0x5a .. 0x65
  localparam logic [7:0] IDX_COEF_LAST = 8'hb9;  // end of coefficient window

  // control register fields
  localparam int CTRL_W            = 11;
  localparam int F_CHAN_EN         = 0;   // channel_filter_enable
  localparam int F_DEC_EN          = 1;   // decimation enable
  localparam int F_DEC_CODE        = 2;   // 3-bit factor code, bits 4:2
  localparam int F_BAND_CODE       = 5;   // 3-bit builtin_band_code, bits 7:5
  localparam int F_SHORT_LEN       = 8;   // shorter_symmetric_length
  localparam int F_USER_WEIGHT     = 9;   // user_weight_enable
  localparam int F_CUSTOM_RESP     = 10;  // custom_response_enable
  localparam logic [10:0] CTRL_RST = 11'h000;

  // status register fields
  localparam int S_LEVEL  = 0;  // fifo level, bits 3:0
  localparam int S_EMPTY  = 4;
  localparam int S_FULL   = 5;
  localparam int S_CUSTOM = 6;

  // decimation factor codes
  localparam logic [2:0] DEC_BY2  = 3'h1;
  localparam logic [2:0] DEC_BY4  = 3'h2;
  localparam logic [2:0] DEC_BY8  = 3'h3;
  localparam logic [2:0] BAND_MAX = 3'h5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // builtin sets, h0 (outer) .. h11 (centre): lp odd, hp odd, lp even, bp1, bp2, hp odd
  localparam logic [11:0] BAND_COEF [0:5][0:11] = '{
    '{12'h000, 12'hff8, 12'h000, 12'h010, 12'h000, 12'hfe0,
      12'h000, 12'h040, 12'h000, 12'hf60, 12'h000, 12'h400},
    '{12'h000, 12'h008, 12'h000, 12'hff0, 12'h000, 12'h020,
      12'h000, 12'hfc0, 12'h000, 12'h0a0, 12'h000, 12'h400},
    '{12'hffc, 12'hff8, 12'hff6, 12'h000, 12'h014, 12'h030,
      12'h050, 12'h074, 12'h094, 12'h0ae, 12'h0c0, 12'h0c8},
    '{12'h006, 12'h000, 12'hff0, 12'hfec, 12'h000, 12'h030,
      12'h040, 12'h000, 12'hf80, 12'hf70, 12'h000, 12'h0c0},
    '{12'hffa, 12'h000, 12'h010, 12'hfec, 12'h000, 12'h030,
      12'hfc0, 12'h000, 12'h080, 12'hf70, 12'h000, 12'h0c0},
    '{12'h004, 12'hff8, 12'h00a, 12'h000, 12'hfec, 12'h030,
      12'hfb0, 12'h074, 12'hf6c, 12'h0ae, 12'hf40, 12'h0c8}
  };
endpackage : dfir_pkg

// [hdl/dfir_fifo_if.sv]
// carrier between the filter datapath and its output fifo
// assumes both ends run on aclk
interface dfir_fifo_if;
  logic                         in_valid;
  logic                         in_ready;
  logic [dfir_pkg::FIFO_W-1:0]  in_data;
  logic                         out_valid;
  logic                         out_ready;
  logic [dfir_pkg::FIFO_W-1:0]  out_data;
  logic [3:0]                   level;

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, level);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, level);
endinterface : dfir_fifo_if

// [hdl/dfir_fifo.sv]
// output fifo with a registered read stage, width and depth as parameters
// assumes one clock and a synchronous active-low reset
module dfir_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  dfir_fifo_if.fifo   port
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      mem_cnt;
  logic [PW:0]      total;

  // handshake decode
  wire pop_out  = port.out_valid & port.out_ready;
  wire push     = port.in_valid & port.in_ready;
  wire out_free = ~port.out_valid | pop_out;
  wire bypass   = push & out_free & (mem_cnt == '0);
  wire load     = out_free & (mem_cnt != '0);
  wire to_mem   = push & ~bypass;

  assign total         = mem_cnt + {{PW{1'b0}}, port.out_valid};
  assign port.in_ready = (total < (PW+1)'(DEPTH));   // honest full, counts the read stage
  assign port.level    = 4'(total);

  // storage and pointers
  always_ff @(posedge aclk) begin
    if (to_mem) begin
      mem[wr_ptr] <= port.in_data;
    end
    if (!aresetn) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      mem_cnt <= '0;
    end else begin
      if (to_mem) wr_ptr <= wr_ptr + 1'b1;
      if (load) rd_ptr <= rd_ptr + 1'b1;
      mem_cnt <= mem_cnt + (PW+1)'(to_mem) - (PW+1)'(load);
    end
  end

  // registered read stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port.out_valid <= 1'b0;
      port.out_data  <= '0;
    end else if (load) begin
      port.out_valid <= 1'b1;
      port.out_data  <= mem[rd_ptr];
    end else if (bypass) begin
      port.out_valid <= 1'b1;
      port.out_data  <= port.in_data;
    end else if (pop_out) begin
      port.out_valid <= 1'b0;
    end
  end
endmodule : dfir_fifo

// [hdl/dfir_top.sv]
// decimating symmetric fir filter for one converter channel, axi4-lite registers
// assumes samples synchronous to aclk (40 MHz), synchronous active-low reset
// Functional notes
// - by default the filter is a 24-tap fir whose coefficients mirror about the centre.
// - every coefficient is a 12-bit two's-complement value.
// - with shorter_symmetric_length set the filter becomes a 23-tap symmetric fir.
// - a builtin band uses its fixed coefficient set, never the user-loaded values.
// - with user_weight_enable set, software loads h0..h11 in the 0x5a..0xb9 window and the filter uses them.
// - with decimation and channel_filter_enable both set the output rate drops by 2, 4 or 8 for codes 001, 010, 011.
// - a 3-bit builtin_band_code 000..101 picks a builtin set, or custom coefficients are chosen.
module dfir_top (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [dfir_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [dfir_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [dfir_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [dfir_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic [dfir_pkg::SAMPLE_W-1:0]  sample_data,
  input  wire logic                           sample_valid,
  output logic                                sample_ready,
  output logic [dfir_pkg::OUT_W-1:0]          out_data,
  output logic                                out_valid,
  input  wire logic                           out_ready
);
  localparam int NT = dfir_pkg::NUM_TAPS;
  localparam int NC = dfir_pkg::NUM_COEF;

  // register and bus state
  logic [dfir_pkg::CTRL_W-1:0]    ctrl;
  logic [dfir_pkg::COEF_W-1:0]    user_coef [0:NC-1];
  logic                           aw_held;
  logic                           w_held;
  logic [7:0]                     wr_idx;
  logic [dfir_pkg::DATA_W-1:0]    wdata_q;
  logic [3:0]                     wstrb_q;

  // delay line, taps[0] newest
  logic [dfir_pkg::SAMPLE_W-1:0]  taps [0:NT-1];
  logic                           keep_d;
  logic [2:0]                     dec_cnt;

  // result stage
  logic [dfir_pkg::OUT_W-1:0]     result;
  logic                           result_valid;
  logic [dfir_pkg::ACC_W-1:0]     acc;

  // carrier to the output fifo
  dfir_fifo_if fifo_bus ();

  // control field decode
  wire       chan_en     = ctrl[dfir_pkg::F_CHAN_EN];
  wire       dec_en      = ctrl[dfir_pkg::F_DEC_EN];
  wire [2:0] dec_code    = ctrl[dfir_pkg::F_DEC_CODE +: 3];
  wire [2:0] band_code   = ctrl[dfir_pkg::F_BAND_CODE +: 3];
  wire       short_len   = ctrl[dfir_pkg::F_SHORT_LEN];
  wire       use_custom  = ctrl[dfir_pkg::F_USER_WEIGHT] | ctrl[dfir_pkg::F_CUSTOM_RESP];
  wire [2:0] band_sel    = (band_code > dfir_pkg::BAND_MAX) ? 3'h0 : band_code;

  // write commit once address and data are both held
  // waits while an answer is pending
  wire        commit   = aw_held & w_held & ~s_axi_bvalid;
  wire [31:0] wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire        wr_ctrl  = commit & (wr_idx == dfir_pkg::IDX_CTRL);
  wire        wr_range = (wr_idx == dfir_pkg::IDX_CTRL) | (wr_idx == dfir_pkg::IDX_STATUS) |
                         ((wr_idx >= dfir_pkg::IDX_COEF_BASE) & (wr_idx <= dfir_pkg::IDX_COEF_LAST));

  // read decode and data selection
  wire [7:0]  rd_idx    = s_axi_araddr[9:2];
  wire [7:0]  rd_coef_n = rd_idx - dfir_pkg::IDX_COEF_BASE;
  wire        rd_coef   = (rd_idx >= dfir_pkg::IDX_COEF_BASE) & (rd_coef_n < 8'(NC));
  wire        rd_window = (rd_idx >= dfir_pkg::IDX_COEF_BASE) & (rd_idx <= dfir_pkg::IDX_COEF_LAST);
  wire        rd_ctrl   = (rd_idx == dfir_pkg::IDX_CTRL);
  wire        rd_stat   = (rd_idx == dfir_pkg::IDX_STATUS);
  wire        rd_ok     = rd_ctrl | rd_stat | rd_window;
  wire [31:0] status_w  = {25'h0000000, use_custom, ~fifo_bus.in_ready,
                           ~(fifo_bus.level != 4'h0), fifo_bus.level};
  wire [31:0] coef_rd   = rd_coef ? {{20{user_coef[rd_coef_n[3:0]][11]}}, user_coef[rd_coef_n[3:0]]} : 32'h0;
  // unmapped reads give zero
  wire [31:0] rd_mux    = rd_ctrl ? {21'h000000, ctrl} : (rd_stat ? status_w : coef_rd);

  // write address channel
  // awready low until commit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b0;
      wr_idx        <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b1;
      wr_idx        <= s_axi_awaddr[9:2];
    end else if (commit) begin
      aw_held       <= 1'b0;
    end else if (!aw_held) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel
  // wready low until commit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b0;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else if (commit) begin
      w_held       <= 1'b0;
    end else if (!w_held) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response
  // bvalid stands until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dfir_pkg::RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_range ? dfir_pkg::RESP_OKAY : dfir_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one outstanding read
  // arready back after the answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= dfir_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? dfir_pkg::RESP_OKAY : dfir_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // control register with byte lanes
  // only bits 10:0 exist
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= dfir_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= (ctrl & ~wmask[10:0]) | (wdata_q[10:0] & wmask[10:0]);
    end
  end

  // user coefficients, coefficient pairs, products and tap shift per entry
  logic signed [dfir_pkg::COEF_W-1:0]   coef_sel [0:NC-1];
  logic signed [dfir_pkg::SAMPLE_W:0]   pair_sum [0:NC-1];
  logic signed [24:0]                   prod     [0:NC-1];
  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_coef
      localparam logic [7:0] MY_IDX = dfir_pkg::IDX_COEF_BASE + 8'(gi);
      wire wr_me = commit & (wr_idx == MY_IDX);
      // 12-bit signed user weight, low two byte lanes
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          user_coef[gi] <= 12'h000;
        end else if (wr_me) begin
          user_coef[gi] <= (user_coef[gi] & ~wmask[11:0]) | (wdata_q[11:0] & wmask[11:0]);
        end
      end

      // builtin set wins unless custom weights are chosen
      assign coef_sel[gi] = use_custom ? user_coef[gi] : dfir_pkg::BAND_COEF[band_sel][gi];

      // mirrored pair: 23-k in 24-tap form, 22-k in 23-tap form, centre counted once
      if (gi == NC - 1) begin : g_centre
        assign pair_sum[gi] = short_len ? 13'(signed'(taps[gi]))
                                        : 13'(signed'(taps[gi])) + 13'(signed'(taps[NT-1-gi]));
      end else begin : g_pair
        assign pair_sum[gi] = 13'(signed'(taps[gi])) +
                              13'(signed'(short_len ? taps[NT-2-gi] : taps[NT-1-gi]));
      end
      // 25-bit signed product
      assign prod[gi] = coef_sel[gi] * pair_sum[gi];
    end

    // one shift stage per tap
    for (gi = 1; gi < NT; gi++) begin : g_tap
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          taps[gi] <= 12'h000;
        end else if (sample_valid && sample_ready) begin
          taps[gi] <= taps[gi-1];
        end
      end
    end
  endgenerate

  // accumulate all pair products
  // 29 bits hold twelve products
  always_comb begin
    acc = '0;
    for (int k = 0; k < NC; k++) begin
      acc = acc + 29'(prod[k]);
    end
  end

  // scale by 2^-11 and saturate to the output width
  // floor rounding, low bits dropped
  wire signed [17:0] scaled  = 18'(signed'(acc) >>> dfir_pkg::FRAC_W);
  wire               sat_hi  = (scaled > 18'sh07fff);
  wire               sat_lo  = (scaled < -18'sh08000);
  wire [15:0]        sat_val = sat_hi ? 16'h7fff : (sat_lo ? 16'h8000 : scaled[15:0]);
  wire [15:0]        raw_val = 16'(signed'(taps[0]));

  // decimation: last phase of the counter per factor code
  wire [2:0] dec_last = (!dec_en || !chan_en) ? 3'h0 :
                        (dec_code == dfir_pkg::DEC_BY2) ? 3'h1 :
                        (dec_code == dfir_pkg::DEC_BY4) ? 3'h3 :
                        (dec_code == dfir_pkg::DEC_BY8) ? 3'h7 : 3'h0;
  wire       accept   = sample_valid & sample_ready;
  wire       keep_now = (dec_cnt == 3'h0);
  // words already promised to the fifo
  wire [4:0] in_flight = 5'(fifo_bus.level) + 5'(keep_d) + 5'(result_valid) + 5'(accept & keep_now);
  wire       next_sample_ready = (in_flight <= 5'(dfir_pkg::FIFO_D - 1));

  // newest sample enters the delay line, decimation phase advances
  // phase wraps on a smaller factor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taps[0] <= 12'h000;
      dec_cnt <= 3'h0;
      keep_d  <= 1'b0;
    end else begin
      keep_d <= accept & keep_now;
      if (accept) begin
        taps[0] <= sample_data;
        dec_cnt <= (dec_cnt >= dec_last) ? 3'h0 : dec_cnt + 3'h1;
      end
    end
  end

  // result stage feeding the fifo; ready looks ahead at every item in flight
  // raw sample passes with filter off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result       <= 16'h0000;
      result_valid <= 1'b0;
      sample_ready <= 1'b0;
    end else begin
      sample_ready <= next_sample_ready;
      result_valid <= keep_d;
      if (keep_d) begin
        result <= chan_en ? sat_val : raw_val;
      end
    end
  end

  // push never refused, ready looked ahead
  assign fifo_bus.in_valid  = result_valid;
  assign fifo_bus.in_data   = result;
  assign fifo_bus.out_ready = out_ready;

  dfir_fifo #(
    .WIDTH (dfir_pkg::FIFO_W),
    .DEPTH (dfir_pkg::FIFO_D)
  ) u_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .port    (fifo_bus.fifo)
  );

  // outputs straight from the fifo read register
  assign out_valid = fifo_bus.out_valid;
  assign out_data  = fifo_bus.out_data;
endmodule : dfir_top

// [tb/dfir_sva.sv]
// checker for dfir_top: bus answer timing and holding of stream outputs
// assumes it is bound to dfir_top and sees only its ports
module dfir_chk (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic [dfir_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [dfir_pkg::OUT_W-1:0]  out_data,
  input wire logic                        out_valid,
  input wire logic                        out_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // request steps: both write halves taken together, read address taken
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer; s_rd_taken |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");
  property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  a_out_hold: assert property (p_out_hold) else $error("output word dropped");
  property p_rst_quiet; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !out_valid; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
endmodule : dfir_chk

bind dfir_top dfir_chk dfir_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .out_data, .out_valid, .out_ready);

// [tb/dfir_stream_model.sv]
// stream partner: converter sample source and output sink around the filter
// assumes the bench fills src_q, reads got and sets stall and slow
module dfir_stream_model (
  input  wire logic        aclk,
  output logic [11:0]      sample_data,
  output logic             sample_valid,
  input  wire logic        sample_ready,
  input  wire logic [15:0] out_data,
  input  wire logic        out_valid,
  output logic             out_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] src_q [$];
  logic [15:0] got [$];
  bit          stall = 0;
  bit          slow = 0;
  bit          tick = 0;
  initial begin
    sample_data = 12'h000;
    sample_valid = 1'h0;
    out_ready = 1'h0;
  end
  // source: hold each sample until taken, inverted data once released
  always @(posedge aclk) begin
    tick <= ~tick;
    if ((!sample_valid || sample_ready) && src_q.size() != 0 && (!slow || tick)) begin
      sample_valid <= 1'h1;
      sample_data  <= src_q.pop_front();
    end else if (sample_valid && sample_ready) begin
      sample_valid <= 1'h0;
      sample_data  <= ~sample_data;
    end
  end
  // sink: records each word taken, stalls on request
  always @(posedge aclk) begin
    if (out_valid && out_ready) got.push_back(out_data);
    out_ready <= !stall && (!slow || tick);
  end
endmodule : dfir_stream_model

// [tb/decimating_fir_filter_test.sv]
// self-checking bench for dfir_top: registers, impulse responses, decimation, fifo
// assumes the stream model as partner and the checker bound to dfir_top
module decimating_fir_filter_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed { logic [9:0] a; logic [31:0] w, d; logic [1:0] wr, rr; } dfir_row_t;
  logic        aclk = 0, aresetn = 0;
  logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [11:0] sample_data, cu [12];
  logic        sample_valid, sample_ready, out_valid, out_ready;
  logic [15:0] out_data;
  int          mismatches = 0, tests_run = 0;
  bit          sh;
  // register rows: status, coefficient ends, empty window, unmapped, control
  dfir_row_t rows [6] = '{'{10'h004, 32'h3f, 32'h10, 2'h0, 2'h0}, '{10'h168, 32'h800, 32'hfffff800, 2'h0, 2'h0},
    '{10'h194, 32'h7fe, 32'h7fe, 2'h0, 2'h0}, '{10'h198, 32'h123, 32'h0, 2'h0, 2'h0},
    '{10'h3fc, 32'h5, 32'h0, 2'h2, 2'h2}, '{10'h000, 32'hffffffff, 32'h7ff, 2'h0, 2'h0}};

  always #12.5 aclk = ~aclk;

  dfir_top dfir_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_data,
    .sample_valid, .sample_ready, .out_data, .out_valid, .out_ready);
  dfir_stream_model dfir_stream_model_inst (.aclk, .sample_data, .sample_valid, .sample_ready, .out_data,
    .out_valid, .out_ready);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // bus write: both halves offered together, each released when taken
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] w, output logic [1:0] rsp);
    bit aw_on = 1;
    bit w_on = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= w;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw_on || w_on) begin
      @(posedge aclk);
      if (aw_on && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (aw_on && s_axi_awready) aw_on = 0;
      if (w_on && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (w_on && s_axi_wready) w_on = 0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axi_wr

  // bus read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [9:0] a, output logic [31:0] rd, output logic [1:0] rsp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axi_rd

  task automatic wait_out(input int n);
    int t = 0;
    while (dfir_stream_model_inst.got.size() < n && t < 3000) begin
      @(posedge aclk);
      t++;
    end
    repeat (12) @(posedge aclk);
    chk(32'(dfir_stream_model_inst.got.size()), 32'(n));
  endtask : wait_out

  // impulse of 1024 after a zero flush; each output is the tap weight halved
  task automatic run_fir(input logic [31:0] ctrl, input logic [11:0] h [12], input bit short_len);
    logic [11:0] c;
    logic [15:0] e;
    axi_wr(10'h000, ctrl, r);
    dfir_stream_model_inst.got.delete();
    for (int k = 0; k < 48; k++) dfir_stream_model_inst.src_q.push_back(k == 24 ? 12'h400 : 12'h000);
    wait_out(48);
    for (int k = 0; k < 24; k++) begin
      c = (short_len && k == 23) ? 12'h000 : h[k < 12 ? k : (short_len ? 22 - k : 23 - k)];
      e = {{4{c[11]}}, c};
      chk({16'h0, dfir_stream_model_inst.got[24 + k]}, {16'h0, e[15], e[15:1]});
    end
    $display("filter run %h done", ctrl);
  endtask : run_fir

  // watchdog: the sequence needs a few thousand cycles
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(10'h000, d, r);
    chk(d, 32'h0);
    axi_rd(10'h004, d, r);
    chk(d, 32'h10);
    $display("reset test done");
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].w, r);
      chk(r, rows[i].wr);
      axi_rd(rows[i].a, d, r);
      chk(d, rows[i].d);
      chk(r, rows[i].rr);
    end
    $display("register rows done");
    // weights are real values times 2048, all negative
    for (int i = 0; i < 12; i++) begin
      cu[i] = 12'h802 + 12'(36 * i);
      axi_wr(10'h168 + 10'(4 * i), {20'h0, cu[i]}, r);
    end
    run_fir(32'h201, cu, 0);
    axi_rd(10'h004, d, r);
    chk(d, 32'h50);
    dfir_stream_model_inst.slow <= 1'h1;
    run_fir(32'h501, cu, 1);
    dfir_stream_model_inst.slow <= 1'h0;
    // band codes 110 and 111 fall back to set 0
    for (int b = 0; b < 8; b++) begin
      sh = (b < 2 || b == 5);
      run_fir(32'h1 | 32'(b) << 5 | 32'(sh) << 8, dfir_pkg::BAND_COEF[b > 5 ? 0 : b], sh);
    end
    // factor codes 000..100: 48 samples give 48, 24, 12, 6, 48 words
    for (int c = 0; c < 5; c++) begin
      axi_wr(10'h000, 32'h203 | 32'(c) << 2, r);
      dfir_stream_model_inst.got.delete();
      repeat (48) dfir_stream_model_inst.src_q.push_back(12'h000);
      wait_out(48 >> (c & 3));
    end
    $display("decimation test done");
    // fifo fill with the sink stalled, then drain
    axi_wr(10'h000, 32'h0, r);
    dfir_stream_model_inst.got.delete();
    dfir_stream_model_inst.stall <= 1'h1;
    for (int i = 0; i < 12; i++) dfir_stream_model_inst.src_q.push_back(12'h801 + 12'(i));
    repeat (40) @(posedge aclk);
    chk({31'h0, sample_ready}, 32'h0);
    axi_rd(10'h004, d, r);
    chk(d, 32'h28);
    dfir_stream_model_inst.stall <= 1'h0;
    wait_out(12);
    for (int i = 0; i < 12; i++) chk({16'h0, dfir_stream_model_inst.got[i]}, {20'hf, 12'h801 + 12'(i)});
    axi_rd(10'h004, d, r);
    chk(d, 32'h10);
    $display("fifo test done");
    tally_and_finish();
  end
endmodule : decimating_fir_filter_test
